// File: verilog/ext_irq_pkg.sv
// constants for the external pin interrupt unit
// Function
// - reset always starts at address 0x0000
// - fixed vector addresses 0x0001 to 0x000A
// - pins fire even when driven as outputs
// - any masked pin toggle raises group request
// - pin change detected without any clock
// - sense field picks level, change, fall, rise
// - edges recognised only with I/O clock running
// - low level detected without the I/O clock
// - level mode requests while pin stays low
// - level gone early: wake, but no interrupt
// - pin sampled first; long pulses always caught
// - pin interrupt needs global and own enable
// - pin flag set on edge, cleared by vector/W1C
// - pin flag reads zero in level mode
// - change flag set on change, cleared by vector/W1C
// - change interrupt needs group and global enable
// - each mask bit enables one watched pin
// - unused register bits always read zero
package ext_irq_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SENSE = 6'h15;
    localparam logic [5:0] IDX_EXT_MASK = 6'h14;
    localparam logic [5:0] IDX_EXT_FLAGS = 6'h13;
    localparam logic [5:0] IDX_CHG_CTRL = 6'h12;
    localparam logic [5:0] IDX_CHG_FLAGS = 6'h11;
    localparam logic [5:0] IDX_CHG_MASK = 6'h10;

    // field positions and reset values
    localparam int SENSE_LSB = 0;
    localparam int ENABLE_BIT = 0;
    localparam int FLAG_BIT = 0;
    localparam int PIN_COUNT = 4;
    localparam logic [1:0] SENSE_RESET = 2'h0;
    localparam logic [3:0] CHG_MASK_RESET = 4'h0;

    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_t;

    // program addresses of vectors
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_EXT = 16'h0001;
    localparam logic [15:0] VEC_CHANGE = 16'h0002;
    localparam logic [15:0] VEC_ADC = 16'h000A;
    localparam int PERIPH_COUNT = 8;
    localparam int SRC_COUNT = 10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register select codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_SENSE = 3'h1;
    localparam logic [2:0] SEL_EXT_MASK = 3'h2;
    localparam logic [2:0] SEL_EXT_FLAGS = 3'h3;
    localparam logic [2:0] SEL_CHG_CTRL = 3'h4;
    localparam logic [2:0] SEL_CHG_FLAGS = 3'h5;
    localparam logic [2:0] SEL_CHG_MASK = 3'h6;

endpackage

// File: verilog/ext_irq_unit.sv
// external pin and pin change interrupt unit with axi4-lite registers
module ext_irq_unit
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pads, read back even while driven as outputs
    input wire logic ext_irq_pin,
    input wire logic [3:0] change_watch_pins,
    // clocking and sleep
    input wire logic io_clk_run,
    output logic wake_req,
    // core side
    input wire logic core_global_ie,
    input wire logic [7:0] periph_req,
    output logic irq_req,
    output logic [15:0] irq_vector,
    input wire logic irq_ack,
    output logic [7:0] periph_ack,
    output logic [15:0] reset_vector
);

    ////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        logic [5:0] idx;
        idx = a[7:2];
        if (a[1:0] != 2'h0) begin
            return SEL_NONE;
        end else if (idx == IDX_SENSE) begin
            return SEL_SENSE;
        end else if (idx == IDX_EXT_MASK) begin
            return SEL_EXT_MASK;
        end else if (idx == IDX_EXT_FLAGS) begin
            return SEL_EXT_FLAGS;
        end else if (idx == IDX_CHG_CTRL) begin
            return SEL_CHG_CTRL;
        end else if (idx == IDX_CHG_FLAGS) begin
            return SEL_CHG_FLAGS;
        end else if (idx == IDX_CHG_MASK) begin
            return SEL_CHG_MASK;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // masked pins that differ from the last sampled value
    function automatic logic masked_change(input logic [3:0] now_v, input logic [3:0] last_v,
            input logic [3:0] mask_v);
        return |((now_v ^ last_v) & mask_v);
    endfunction

    ////////////////////////////////////////////////////////////////
    // registers and state

    sense_t sense_r;
    logic ext_en_r;
    logic ext_flag_r;
    logic chg_en_r;
    logic chg_flag_r;
    logic [3:0] chg_mask_r;

    logic ext_meta_r;
    logic ext_sync_r;
    logic ext_prev_r;
    logic [3:0] chg_meta_r;
    logic [3:0] chg_sync_r;
    logic [3:0] chg_prev_r;

    logic aw_held_r;
    logic [7:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic irq_req_r;
    logic [3:0] pres_idx_r;
    logic [15:0] irq_vector_r;

    logic do_write;
    logic [2:0] wr_sel;
    logic lane0;
    logic level_mode;
    logic ext_edge_hit;
    logic change_group_request;
    logic ext_req;
    logic chg_req;
    logic [9:0] src_req;
    logic ack_ext;
    logic ack_chg;
    logic irq_req_nxt;
    logic [3:0] pres_idx_nxt;
    logic [31:0] rd_word;
    logic reg_wr;
    logic ext_w1c;
    logic chg_w1c;
    logic level_wake;
    logic change_wake;

    assign reset_vector = VEC_RESET;

    ////////////////////////////////////////////////////////////////
    // pad synchronisers and detection

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_meta_r <= 1'b1;
            ext_sync_r <= 1'b1;
        end else begin
            ext_meta_r <= ext_irq_pin;
            ext_sync_r <= ext_meta_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chg_meta_r <= 4'h0;
            chg_sync_r <= 4'h0;
        end else begin
            chg_meta_r <= change_watch_pins;
            chg_sync_r <= chg_meta_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_prev_r <= 1'b1;
        end else begin
            ext_prev_r <= ext_sync_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chg_prev_r <= 4'h0;
        end else begin
            chg_prev_r <= chg_sync_r;
        end
    end

    assign level_mode = (sense_r == SENSE_LOW);

    // edges only count while the i/o clock runs
    always_comb begin
        ext_edge_hit = 1'b0;
        if (io_clk_run) begin
            case (sense_r)
                SENSE_ANY: ext_edge_hit = ext_sync_r ^ ext_prev_r;
                SENSE_FALL: ext_edge_hit = ext_prev_r & ~ext_sync_r;
                SENSE_RISE: ext_edge_hit = ~ext_prev_r & ext_sync_r;
                default: ext_edge_hit = 1'b0;
            endcase
        end
    end

    // either direction on any masked pin
    assign change_group_request = masked_change(chg_sync_r, chg_prev_r, chg_mask_r);

    // clockless wake paths compare the raw pads directly
    assign level_wake = level_mode & ext_en_r & ~ext_irq_pin;
    assign change_wake = chg_en_r
        & (chg_flag_r | masked_change(change_watch_pins, chg_prev_r, chg_mask_r));
    assign wake_req = level_wake | change_wake;

    ////////////////////////////////////////////////////////////////
    // flags

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_flag_r <= 1'b0;
        end else if (level_mode) begin
            ext_flag_r <= 1'b0;
        end else if (ext_edge_hit) begin
            ext_flag_r <= 1'b1;
        end else if (ack_ext || ext_w1c) begin
            ext_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chg_flag_r <= 1'b0;
        end else if (change_group_request) begin
            chg_flag_r <= 1'b1;
        end else if (ack_chg || chg_w1c) begin
            chg_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // request arbitration toward the core

    // level mode asks for as long as the pin is low
    assign ext_req = core_global_ie & ext_en_r
        & (level_mode ? ~ext_sync_r : ext_flag_r);
    assign chg_req = core_global_ie & chg_en_r & chg_flag_r;
    assign src_req = {periph_req & {PERIPH_COUNT{core_global_ie}}, chg_req, ext_req};

    assign ack_ext = irq_ack & irq_req_r & (pres_idx_r == 4'h0);
    assign ack_chg = irq_ack & irq_req_r & (pres_idx_r == 4'h1);

    // scan downward so the lowest vector wins
    always_comb begin
        irq_req_nxt = 1'b0;
        pres_idx_nxt = 4'h0;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (src_req[i]) begin
                irq_req_nxt = 1'b1;
                pres_idx_nxt = 4'(i);
            end
        end
        // one idle cycle after a take avoids a double take
        if (irq_ack) begin
            irq_req_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_req_r <= 1'b0;
            pres_idx_r <= 4'h0;
            irq_vector_r <= VEC_EXT;
        end else begin
            irq_req_r <= irq_req_nxt;
            pres_idx_r <= pres_idx_nxt;
            irq_vector_r <= VEC_EXT + {12'h000, pres_idx_nxt};
        end
    end

    assign irq_req = irq_req_r;
    assign irq_vector = irq_vector_r;

    always_comb begin
        periph_ack = 8'h00;
        if (irq_ack && irq_req_r && pres_idx_r >= 4'h2) begin
            periph_ack[3'(pres_idx_r - 4'h2)] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    assign awready = ~aw_held_r & ~bvalid_r;
    assign wready = ~w_held_r & ~bvalid_r;
    assign do_write = aw_held_r & w_held_r;
    assign wr_sel = reg_sel(aw_addr_r);
    assign lane0 = w_strb_r[0];

    // register write and write-one-to-clear strobes, lane 0 only
    assign reg_wr = do_write & lane0;
    assign ext_w1c = reg_wr & (wr_sel == SEL_EXT_FLAGS) & w_data_r[FLAG_BIT];
    assign chg_w1c = reg_wr & (wr_sel == SEL_CHG_FLAGS) & w_data_r[FLAG_BIT];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end else if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= awaddr;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    // control registers; reserved bits are never stored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sense_r <= sense_t'(SENSE_RESET);
            ext_en_r <= 1'b0;
            chg_en_r <= 1'b0;
            chg_mask_r <= CHG_MASK_RESET;
        end else if (reg_wr) begin
            if (wr_sel == SEL_SENSE) begin
                sense_r <= sense_t'(w_data_r[SENSE_LSB +: 2]);
            end else if (wr_sel == SEL_EXT_MASK) begin
                ext_en_r <= w_data_r[ENABLE_BIT];
            end else if (wr_sel == SEL_CHG_CTRL) begin
                chg_en_r <= w_data_r[ENABLE_BIT];
            end else if (wr_sel == SEL_CHG_MASK) begin
                chg_mask_r <= w_data_r[PIN_COUNT-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    always_comb begin
        rd_word = 32'h0000_0000;
        case (reg_sel(araddr))
            SEL_SENSE: rd_word[SENSE_LSB +: 2] = sense_r;
            SEL_EXT_MASK: rd_word[ENABLE_BIT] = ext_en_r;
            SEL_EXT_FLAGS: rd_word[FLAG_BIT] = ext_flag_r & ~level_mode;
            SEL_CHG_CTRL: rd_word[ENABLE_BIT] = chg_en_r;
            SEL_CHG_FLAGS: rd_word[FLAG_BIT] = chg_flag_r;
            SEL_CHG_MASK: rd_word[PIN_COUNT-1:0] = chg_mask_r;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    assign arready = ~rvalid_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= (reg_sel(araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

endmodule // ext_irq_unit

// File: tb/ext_irq_unit_properties.sv
// port assertions for the interrupt unit
module ext_irq_unit_properties
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register bus
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // core side
    input wire logic core_global_ie,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic irq_ack,
    input wire logic [7:0] periph_ack,
    input wire logic [15:0] reset_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    reset_addr_a: assert property (reset_vector == VEC_RESET) else $error("bad reset address");
    vector_range_a: assert property (irq_req |-> irq_vector inside {[VEC_EXT:VEC_ADC]})
        else $error("vector out of range");
    global_gate_a: assert property (!core_global_ie |=> !irq_req) else $error("ungated request");
    ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req) else $error("request after ack");
    periph_ack_a: assert property (irq_req && irq_ack && irq_vector > VEC_CHANGE
        |-> periph_ack == 8'h01 << (irq_vector - 16'h0003)) else $error("wrong peripheral ack");
    stray_ack_a: assert property (periph_ack != 8'h00 |-> irq_req && irq_ack) else $error("stray ack");
    b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("write response dropped");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
    ar_block_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
endmodule // ext_irq_unit_properties
bind ext_irq_unit ext_irq_unit_properties i_props (.mclk(mclk), .rst(rst), .bvalid(bvalid), .bready(bready),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .core_global_ie(core_global_ie),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .periph_ack(periph_ack),
    .reset_vector(reset_vector));

// File: tb/core_model.sv
// processor core stand-in taking vectored requests
module core_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // request side, dly sets response speed
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [3:0] dly,
    output logic irq_ack,
    // record of taken vectors
    output logic [15:0] last_vec,
    output int taken
);
    timeunit 1ns;
    timeprecision 1ps;
    int w;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'h0;
            w <= 0;
            taken <= 0;
            last_vec <= 16'h0000;
        end else begin
            irq_ack <= 1'h0;
            if (irq_ack && irq_req) begin
                taken <= taken + 1;
                last_vec <= irq_vector;
            end
            if (irq_req && !irq_ack) begin
                irq_ack <= (w >= int'(dly));
                w <= (w >= int'(dly)) ? 0 : w + 1;
            end
        end
    end
endmodule // core_model

// File: tb/external_pin_interrupt_unit_tb_top.sv
// testbench for the external pin interrupt unit
module external_pin_interrupt_unit_tb_top import ext_irq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic ext_irq_pin = 1'h1, io_clk_run = 1'h1, core_global_ie = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, periph_req = 8'h00, periph_raise = 8'h00, periph_ack;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF, change_watch_pins = 4'h0, dly = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq_req, irq_ack, wake_req;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] irq_vector, reset_vector, last_vec;
    logic [5:0] ix [4] = '{IDX_SENSE, IDX_EXT_MASK, IDX_CHG_CTRL, IDX_CHG_MASK};
    logic [7:0] mk [4] = '{8'h03, 8'h01, 8'h01, 8'h0F};
    int taken, fail_count = 0, check_count = 0;
    always #2 mclk = ~mclk;
    ext_irq_unit i_dut (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .ext_irq_pin(ext_irq_pin), .change_watch_pins(change_watch_pins),
        .io_clk_run(io_clk_run), .wake_req(wake_req), .core_global_ie(core_global_ie), .periph_req(periph_req),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .periph_ack(periph_ack),
        .reset_vector(reset_vector));
    core_model i_core (.mclk(mclk), .rst(rst), .irq_req(irq_req), .irq_vector(irq_vector), .dly(dly),
        .irq_ack(irq_ack), .last_vec(last_vec), .taken(taken));
    // peripheral requests raised by the sequence, dropped once served
    always @(posedge mclk) begin
        periph_req <= (periph_req | periph_raise) & ~periph_ack;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic ga, gw, gb;
        @(posedge mclk);
        awaddr <= {a, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge mclk);
            ga = awready;
            gw = wready;
            gb = bvalid;
            resp = bresp;
            @(posedge mclk);
            if (ga) awvalid <= 1'h0;
            if (gw) wvalid <= 1'h0;
        end while (!gb);
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic g, gr;
        logic [31:0] d;
        @(posedge mclk);
        araddr <= {a, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge mclk);
            g = arready;
            gr = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge mclk);
            if (g) arvalid <= 1'h0;
        end while (!gr);
        rready <= 1'h0;
        chk(d, {24'h0, e});
    endtask
    task automatic drive(input logic p, input logic [3:0] c);
        @(posedge mclk);
        ext_irq_pin <= p;
        change_watch_pins <= c;
        repeat (6) @(posedge mclk);
    endtask
    task automatic take(input logic [15:0] e);
        int n;
        n = taken;
        wait (taken != n);
        #1;
        chk(last_vec, e);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            rd(ix[i], 8'h00);
            wr(ix[i], 8'hFF);
            rd(ix[i], mk[i]);
            wr(ix[i], 8'h00);
        end
        rd(IDX_EXT_FLAGS, 8'h00);
        rd(IDX_CHG_FLAGS, 8'h00);
        rd(6'h00, 8'h00);
        chk(resp, RESP_SLVERR);
        wr(6'h00, 8'hFF);
        chk(resp, RESP_SLVERR);
        $display("register test done");
        for (int m = 1; m < 4; m++) begin
            wr(IDX_SENSE, 8'(m));
            wr(IDX_EXT_FLAGS, 8'h01);
            drive(1'h0, 4'h0);
            rd(IDX_EXT_FLAGS, {7'h0, m != 3});
            wr(IDX_EXT_FLAGS, 8'h01);
            rd(IDX_EXT_FLAGS, 8'h00);
            drive(1'h1, 4'h0);
            rd(IDX_EXT_FLAGS, {7'h0, m != 2});
        end
        wr(IDX_EXT_FLAGS, 8'h01);
        io_clk_run <= 1'h0;
        drive(1'h0, 4'h0);
        drive(1'h1, 4'h0);
        io_clk_run <= 1'h1;
        rd(IDX_EXT_FLAGS, 8'h00);
        $display("edge test done");
        wr(IDX_SENSE, 8'h00);
        wr(IDX_EXT_MASK, 8'h01);
        dly <= 4'h3;
        drive(1'h0, 4'h0);
        @(negedge mclk);
        chk(wake_req, 1'h1);
        chk(irq_req, 1'h0);
        rd(IDX_EXT_FLAGS, 8'h00);
        core_global_ie <= 1'h1;
        take(VEC_EXT);
        take(VEC_EXT);
        drive(1'h1, 4'h0);
        @(negedge mclk);
        chk(irq_req, 1'h0);
        chk(wake_req, 1'h0);
        @(posedge mclk);
        core_global_ie <= 1'h0;
        wr(IDX_EXT_MASK, 8'h00);
        $display("level test done");
        dly <= 4'h0;
        wr(IDX_CHG_MASK, 8'h04);
        drive(1'h1, 4'h1);
        rd(IDX_CHG_FLAGS, 8'h00);
        drive(1'h1, 4'h5);
        rd(IDX_CHG_FLAGS, 8'h01);
        wr(IDX_CHG_FLAGS, 8'h01);
        rd(IDX_CHG_FLAGS, 8'h00);
        wr(IDX_CHG_CTRL, 8'h01);
        core_global_ie <= 1'h1;
        @(posedge mclk);
        change_watch_pins <= 4'h1;
        @(negedge mclk);
        chk(wake_req, 1'h1);
        take(VEC_CHANGE);
        rd(IDX_CHG_FLAGS, 8'h00);
        $display("pin change test done");
        core_global_ie <= 1'h0;
        wr(IDX_SENSE, 8'h01);
        wr(IDX_EXT_MASK, 8'h01);
        periph_raise <= 8'h01;
        dly <= 4'h2;
        drive(1'h0, 4'h5);
        periph_raise <= 8'h00;
        core_global_ie <= 1'h1;
        take(VEC_EXT);
        take(VEC_CHANGE);
        take(16'h0003);
        $display("priority test done");
        end_of_test();
    end
    initial begin
        repeat (10000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end
endmodule // external_pin_interrupt_unit_tb_top
